// file: logic/host_memory_address_translator.sv
// Host memory address translator: AXI4-Lite slave to system bus master
//
// Register access over AXI4-Lite and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none

// Function
// - Invert address bit 0 on converted byte accesses outside VMEbus mode
// - Segment shifted left four plus offset
// - Offset in low half, segment high half
// - Segmented host addresses stay below 1 Mbyte
// - Absolute mode uses low 24 bits
// - Absolute mode reaches whole 16 Mbyte space
// - VMEbus: absolute, modifier in bits 24-29
// - Addresses are 32-bit longword objects
// - Longword conversion applied to address objects
// - Without timeout, wait forever for response
// - Timeout after 30 ms: offline, flash BA
// - Two 64-Kbyte windows map onto bus
// - Second window continues first without remapping
// - Pattern decides word and longword conversions
// - Native order: high byte at high address
module host_memory_address_translator #(
	parameter int unsigned TIMEOUT_CYCLES = hmat_pkg::TIMEOUT_CYC,
	parameter int unsigned FLASH_CYCLES   = hmat_pkg::FLASH_CYC
) (
	input  wire logic        mclk_i,          // 50 MHz clock
	input  wire logic        resetn_i,        // Async reset, active low
	input  wire logic [17:0] s_axi_awaddr_i,  // Write address
	input  wire logic        s_axi_awvalid_i, // Write address valid
	output logic             s_axi_awready_o, // Write address ready
	input  wire logic [31:0] s_axi_wdata_i,   // Write data
	input  wire logic [3:0]  s_axi_wstrb_i,   // Write byte strobes
	input  wire logic        s_axi_wvalid_i,  // Write data valid
	output logic             s_axi_wready_o,  // Write data ready
	output logic [1:0]       s_axi_bresp_o,   // Write response
	output logic             s_axi_bvalid_o,  // Write response valid
	input  wire logic        s_axi_bready_i,  // Write response ready
	input  wire logic [17:0] s_axi_araddr_i,  // Read address
	input  wire logic        s_axi_arvalid_i, // Read address valid
	output logic             s_axi_arready_o, // Read address ready
	output logic [31:0]      s_axi_rdata_o,   // Read data
	output logic [1:0]       s_axi_rresp_o,   // Read response
	output logic             s_axi_rvalid_o,  // Read data valid
	input  wire logic        s_axi_rready_i,  // Read data ready
	output logic             sb_req_o,        // Bus cycle request
	output logic             sb_we_o,         // Bus cycle is a write
	output logic [23:0]      sb_addr_o,       // Bus byte address
	output logic [5:0]       sb_am_o,         // VMEbus address modifier
	output logic [3:0]       sb_be_o,         // Bus byte lanes
	output logic [31:0]      sb_wdata_o,      // Bus write data
	input  wire logic        sb_ack_i,        // Bus memory response
	input  wire logic [31:0] sb_rdata_i,      // Bus read data
	output logic             bus_active_led_o,// Lit while on the bus
	output logic [7:0]       status_led_o     // Error code display
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		hmat_pkg::fsm_t state;
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [1:0]  rresp;
		logic [31:0] rdata;
		logic        abs_mode;
		logic        conv_en;
		logic        tmo_en;
		logic        vme;
		logic        conv_word;
		logic        conv_long;
		logic [31:0] addr_raw;
		logic [23:0] base;
		logic [5:0]  am;
		logic        sb_req;
		logic        sb_we;
		logic [23:0] sb_addr;
		logic [3:0]  sb_be;
		logic [31:0] sb_wdata;
		logic        ack_s1;
		logic        ack_s2;
		logic [hmat_pkg::CNT_W-1:0] tmo_cnt;
		logic        offline;
		logic [hmat_pkg::CNT_W-1:0] flash_cnt;
		logic        flash_on;
		logic        led_busy;
		logic [7:0]  led;
	} state_t;

	state_t st;
	state_t next_st;

	// Counters are CNT_W wide; larger figures cannot be served
	if (TIMEOUT_CYCLES < 2
		|| TIMEOUT_CYCLES >= (1 << hmat_pkg::CNT_W)) begin : g_bad_tmo
		$error("TIMEOUT_CYCLES out of range");
	end
	if (FLASH_CYCLES < 2
		|| FLASH_CYCLES >= (1 << hmat_pkg::CNT_W)) begin : g_bad_flash
		$error("FLASH_CYCLES out of range");
	end

	// ----------------------------------------------------------------
	// Helper functions
	// ----------------------------------------------------------------
	// Host native order to local order: swap halves, then bytes in halves
	function automatic logic [31:0] order_fix(input logic [31:0] v,
		input logic wrd, input logic lng);
		logic [31:0] t;
		t = lng ? {v[15:0], v[31:16]} : v;
		order_fix = wrd ? {t[23:16], t[31:24], t[7:0], t[15:8]} : t;
	endfunction

	// Segment in the high half, offset in the low half; wraps at 1 Mbyte
	function automatic logic [19:0] seg_phys(input logic [31:0] v);
		seg_phys = {v[31:16], 4'h0} + {4'h0, v[15:0]};
	endfunction

	// Lowest lane of a strobe set; only one-hot strobes are byte accesses
	function automatic logic [1:0] lane_of(input logic [3:0] s);
		lane_of = s[0] ? 2'h0 : s[1] ? 2'h1 : s[2] ? 2'h2 : 2'h3;
	endfunction

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	logic [31:0] cooked;
	logic [23:0] win_addr;
	logic [31:0] reg_rd;
	logic        wr_win;
	logic        rd_win;
	logic        byte_wr;
	logic [1:0]  lane;

	// Address object after host order compensation
	assign cooked   = st.conv_en ? order_fix(s_axi_wdata_i, st.conv_word,
		st.conv_long) : s_axi_wdata_i;
	assign wr_win   = s_axi_awaddr_i[hmat_pkg::WIN_SEL_BIT];
	assign rd_win   = s_axi_araddr_i[hmat_pkg::WIN_SEL_BIT];
	assign byte_wr  = $onehot(s_axi_wstrb_i);
	assign lane     = lane_of(s_axi_wstrb_i);

	// Both windows are one contiguous span, so no remapping at 64K
	always_comb begin
		logic [23:0] a;
		logic [16:0] ofs;
		a = 24'h0;
		// Offset follows the transfer being taken, not a stale write address
		ofs = st.awready ? s_axi_awaddr_i[hmat_pkg::WIN_OFS_W-1:0]
			: s_axi_araddr_i[hmat_pkg::WIN_OFS_W-1:0];
		a = st.base + {7'h0, ofs};
		if (!st.abs_mode && !st.vme)
			a[23:20] = 4'h0;
		win_addr = a;
	end

	// Register read mux
	always_comb begin
		reg_rd = 32'h0;
		case (s_axi_araddr_i)
			hmat_pkg::REG_CTRL:
				reg_rd = {28'h0, st.vme, st.tmo_en, st.conv_en, st.abs_mode};
			hmat_pkg::REG_ADDR:    reg_rd = st.addr_raw;
			hmat_pkg::REG_STATUS:
				reg_rd = {24'h0, st.led[3:0], st.conv_long, st.conv_word,
					st.offline, st.sb_req};
			hmat_pkg::REG_BASE:    reg_rd = {2'h0, st.am, st.base};
			default:               reg_rd = 32'h0;
		endcase
	end

	always_comb begin
		next_st = st;
		next_st.awready = 1'b0;
		next_st.wready  = 1'b0;
		next_st.arready = 1'b0;
		// Bus response passes two flip-flops before anything reads it
		next_st.ack_s1 = sb_ack_i;
		next_st.ack_s2 = st.ack_s1;

		case (st.state)
			hmat_pkg::ST_IDLE: begin
				if (st.awready) begin
					next_st.bresp = hmat_pkg::RESP_OKAY;
					if (wr_win) begin
						if (st.offline) begin
							next_st.bresp = hmat_pkg::RESP_SLVERR;
							next_st.state = hmat_pkg::ST_BRESP;
							next_st.bvalid = 1'b1;
						end else begin
							next_st.sb_req = 1'b1;
							next_st.sb_we = 1'b1;
							next_st.sb_addr = win_addr;
							next_st.sb_be = s_axi_wstrb_i;
							next_st.sb_wdata = s_axi_wdata_i;
							if (byte_wr) begin
								// Lane follows the mapped bus address, base may be odd
								next_st.sb_be = 4'h1 << win_addr[1:0];
								next_st.sb_wdata = {4{s_axi_wdata_i[8*lane +: 8]}};
								if (st.conv_en && st.conv_word && !st.vme) begin
									next_st.sb_addr[0] = ~win_addr[0];
									next_st.sb_be = 4'h1 << {win_addr[1], ~win_addr[0]};
								end
							end
							next_st.state = hmat_pkg::ST_BUS;
						end
					end else begin
						next_st.state = hmat_pkg::ST_BRESP;
						next_st.bvalid = 1'b1;
						case (s_axi_awaddr_i)
							hmat_pkg::REG_CTRL: begin
								// Idle here, so no bus access sees it change
								next_st.abs_mode = s_axi_wdata_i[hmat_pkg::CTRL_ABS];
								next_st.conv_en = s_axi_wdata_i[hmat_pkg::CTRL_CONV];
								next_st.tmo_en = s_axi_wdata_i[hmat_pkg::CTRL_TMO];
								next_st.vme = s_axi_wdata_i[hmat_pkg::CTRL_VME];
							end
							hmat_pkg::REG_ADDR: begin
								next_st.addr_raw = s_axi_wdata_i;
								if (st.abs_mode || st.vme) begin
									next_st.base = cooked[23:0];
									next_st.am = st.vme ? cooked[29:hmat_pkg::AM_LSB]
										: 6'h0;
								end else begin
									next_st.base = {4'h0, seg_phys(cooked)};
									next_st.am = 6'h0;
								end
							end
							hmat_pkg::REG_PATTERN: begin
								// Lowest byte of the fetched pattern reveals order
								next_st.conv_word =
									(s_axi_wdata_i[7:0] == hmat_pkg::PAT_WORD_SWAP) ||
									(s_axi_wdata_i[7:0] == hmat_pkg::PAT_FULL_REV);
								next_st.conv_long =
									(s_axi_wdata_i[7:0] == hmat_pkg::PAT_HALF_SWAP) ||
									(s_axi_wdata_i[7:0] == hmat_pkg::PAT_FULL_REV);
							end
							hmat_pkg::REG_STATUS, hmat_pkg::REG_BASE: ;
							default: next_st.bresp = hmat_pkg::RESP_DECERR;
						endcase
					end
				end else if (st.arready) begin
					next_st.rresp = hmat_pkg::RESP_OKAY;
					next_st.rdata = reg_rd;
					if (rd_win) begin
						if (st.offline) begin
							next_st.rresp = hmat_pkg::RESP_SLVERR;
							next_st.rdata = 32'h0;
							next_st.state = hmat_pkg::ST_RRESP;
							next_st.rvalid = 1'b1;
						end else begin
							next_st.sb_req = 1'b1;
							next_st.sb_we = 1'b0;
							next_st.sb_addr = {win_addr[23:2], 2'h0};
							next_st.sb_be = 4'hf;
							next_st.state = hmat_pkg::ST_BUS;
						end
					end else begin
						next_st.state = hmat_pkg::ST_RRESP;
						next_st.rvalid = 1'b1;
						if (s_axi_araddr_i > hmat_pkg::REG_PATTERN)
							next_st.rresp = hmat_pkg::RESP_DECERR;
					end
				end else if (!st.ack_s2) begin
					// Wait out the previous response before the next cycle
					if (s_axi_awvalid_i && s_axi_wvalid_i) begin
						next_st.awready = 1'b1;
						next_st.wready = 1'b1;
					end else if (s_axi_arvalid_i) begin
						next_st.arready = 1'b1;
					end
				end
				next_st.tmo_cnt = '0;
			end

			hmat_pkg::ST_BUS: begin
				if (st.ack_s2) begin
					next_st.sb_req = 1'b0;
					next_st.rdata = sb_rdata_i;  // Lane 0 is the lowest address
					next_st.rresp = hmat_pkg::RESP_OKAY;
					next_st.bresp = hmat_pkg::RESP_OKAY;
					next_st.bvalid = st.sb_we;
					next_st.rvalid = !st.sb_we;
					next_st.state = st.sb_we ? hmat_pkg::ST_BRESP
						: hmat_pkg::ST_RRESP;
				end else if (st.tmo_en) begin
					next_st.tmo_cnt = st.tmo_cnt + 1'b1;
					if (st.tmo_cnt == hmat_pkg::CNT_W'(TIMEOUT_CYCLES - 1)) begin
						// Give up the access and leave the bus for good
						next_st.sb_req = 1'b0;
						next_st.offline = 1'b1;
						next_st.rdata = 32'h0;
						next_st.rresp = hmat_pkg::RESP_SLVERR;
						next_st.bresp = hmat_pkg::RESP_SLVERR;
						next_st.bvalid = st.sb_we;
						next_st.rvalid = !st.sb_we;
						next_st.state = st.sb_we ? hmat_pkg::ST_BRESP
							: hmat_pkg::ST_RRESP;
					end
				end
			end

			hmat_pkg::ST_BRESP: begin
				if (s_axi_bready_i) begin
					next_st.bvalid = 1'b0;
					next_st.state = hmat_pkg::ST_IDLE;
				end
			end

			hmat_pkg::ST_RRESP: begin
				if (s_axi_rready_i) begin
					next_st.rvalid = 1'b0;
					next_st.state = hmat_pkg::ST_IDLE;
				end
			end

			default: next_st.state = hmat_pkg::ST_IDLE;
		endcase

		// Indicator follows the request into the same flop edge
		next_st.led_busy = next_st.sb_req;

		// Error code blinks at a regular rate once offline
		if (st.offline) begin
			if (st.flash_cnt == hmat_pkg::CNT_W'(FLASH_CYCLES - 1)) begin
				next_st.flash_cnt = '0;
				next_st.flash_on = !st.flash_on;
			end else begin
				next_st.flash_cnt = st.flash_cnt + 1'b1;
			end
		end
		next_st.led = (next_st.offline && next_st.flash_on) ?
			hmat_pkg::ERR_CODE : 8'h0;
		if (next_st.offline && !st.offline)
			next_st.flash_on = 1'b1;
		if (next_st.offline && !st.offline)
			next_st.led = hmat_pkg::ERR_CODE;
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			st <= '0;
			st.state <= hmat_pkg::ST_IDLE;
			{st.vme, st.tmo_en, st.conv_en, st.abs_mode} <= hmat_pkg::CTRL_RESET;
		end else begin
			st <= next_st;
		end
	end

	// Every output straight from the state register
	assign s_axi_awready_o  = st.awready;
	assign s_axi_wready_o   = st.wready;
	assign s_axi_bresp_o    = st.bresp;
	assign s_axi_bvalid_o   = st.bvalid;
	assign s_axi_arready_o  = st.arready;
	assign s_axi_rdata_o    = st.rdata;
	assign s_axi_rresp_o    = st.rresp;
	assign s_axi_rvalid_o   = st.rvalid;
	assign sb_req_o         = st.sb_req;
	assign sb_we_o          = st.sb_we;
	assign sb_addr_o        = st.sb_addr;
	assign sb_am_o          = st.am;
	assign sb_be_o          = st.sb_be;
	assign sb_wdata_o       = st.sb_wdata;
	assign bus_active_led_o = st.led_busy;
	assign status_led_o     = st.led;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!resetn_i);

	sequence s_byte_wr_taken;
		st.state == hmat_pkg::ST_IDLE && st.awready && wr_win && byte_wr
			&& !st.offline && st.conv_en && st.conv_word && !st.vme;
	endsequence
	sequence s_seg_addr_wr;
		st.state == hmat_pkg::ST_IDLE && st.awready && !wr_win
			&& s_axi_awaddr_i == hmat_pkg::REG_ADDR && !st.conv_en
			&& !st.abs_mode && !st.vme;
	endsequence

	property p_byte_inv;
		logic b0;
		(s_byte_wr_taken, b0 = win_addr[0]) |=> sb_req_o && sb_addr_o[0] == !b0;
	endproperty
	a_byte_inv: assert property (p_byte_inv)
		else $error("byte address bit 0 not inverted");

	property p_seg_calc;
		s_seg_addr_wr |=> st.base[23:20] == 4'h0 && st.base[19:0] ==
			{$past(s_axi_wdata_i[31:16]), 4'h0}
			+ {4'h0, $past(s_axi_wdata_i[15:0])};
	endproperty
	a_seg_calc: assert property (p_seg_calc)
		else $error("segmented base miscomputed");

	property p_seg_limit;
		$rose(sb_req_o) && !st.abs_mode && !st.vme |-> sb_addr_o[23:20] == 4'h0;
	endproperty
	a_seg_limit: assert property (p_seg_limit)
		else $error("segmented access above 1 Mbyte");

	property p_vme_am;
		sb_req_o && st.vme && !st.conv_en |->
			sb_am_o == st.addr_raw[29:hmat_pkg::AM_LSB];
	endproperty
	a_vme_am: assert property (p_vme_am)
		else $error("address modifier not driven");

	property p_no_abandon;
		sb_req_o && !st.tmo_en && !st.ack_s2 |=> sb_req_o;
	endproperty
	a_no_abandon: assert property (p_no_abandon)
		else $error("access abandoned without timeout");

	property p_led_busy;
		sb_req_o |-> bus_active_led_o;
	endproperty
	a_led_busy: assert property (p_led_busy)
		else $error("bus led dark during access");

	property p_offline;
		$rose(st.offline) |-> $past(st.tmo_en) && !sb_req_o
			&& status_led_o == hmat_pkg::ERR_CODE;
	endproperty
	a_offline: assert property (p_offline)
		else $error("offline entry wrong");

	property p_flash;
		st.offline |-> status_led_o == hmat_pkg::ERR_CODE || status_led_o == 8'h0;
	endproperty
	a_flash: assert property (p_flash)
		else $error("status led shows wrong code");

	property p_answer_after_ack;
		sb_req_o && st.ack_s2 |=> !sb_req_o && (s_axi_bvalid_o || s_axi_rvalid_o);
	endproperty
	a_answer_after_ack: assert property (p_answer_after_ack)
		else $error("no answer after bus response");

	property p_cfg_static;
		sb_req_o |=> $stable({st.abs_mode, st.conv_en, st.tmo_en, st.vme});
	endproperty
	a_cfg_static: assert property (p_cfg_static)
		else $error("configuration changed during access");

endmodule

`default_nettype wire

// file: logic/hmat_pkg.sv
// Constants shared by the host memory address translator and its bench
package hmat_pkg;

	// ----------------------------------------------------------------
	// Register map (byte addresses on the AXI4-Lite port)
	// ----------------------------------------------------------------
	localparam int          ADDR_W      = 18;
	localparam logic [17:0] REG_CTRL    = 18'h00000;
	localparam logic [17:0] REG_ADDR    = 18'h00004;
	localparam logic [17:0] REG_STATUS  = 18'h00008;
	localparam logic [17:0] REG_BASE    = 18'h0000c;
	localparam logic [17:0] REG_PATTERN = 18'h00010;
	localparam int          WIN_SEL_BIT = 17;   // Set: two bus windows
	localparam int          WIN_OFS_W   = 17;   // Two 64-Kbyte windows

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int         CTRL_ABS      = 0;
	localparam int         CTRL_CONV     = 1;
	localparam int         CTRL_TMO      = 2;
	localparam int         CTRL_VME      = 3;
	localparam logic [3:0] CTRL_RESET    = 4'h0;
	localparam int         STAT_BUSY     = 0;
	localparam int         STAT_OFFLINE  = 1;
	localparam int         STAT_CONV_WRD = 2;
	localparam int         STAT_CONV_LNG = 3;
	localparam int         AM_LSB        = 24;
	localparam int         SEG_SHIFT     = 4;
	localparam logic [7:0] ERR_CODE      = 8'hba;
	localparam logic [7:0] PAT_WORD_SWAP = 8'h01;
	localparam logic [7:0] PAT_HALF_SWAP = 8'h02;
	localparam logic [7:0] PAT_FULL_REV  = 8'h03;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ      = 50_000_000;
	localparam int TIMEOUT_MS  = 30;
	localparam int TIMEOUT_CYC = CLK_HZ / 1000 * TIMEOUT_MS;
	localparam int FLASH_MS    = 250;
	localparam int FLASH_CYC   = CLK_HZ / 1000 * FLASH_MS;
	localparam int CNT_W       = 24;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_BUS   = 2'b01,
		ST_BRESP = 2'b10,
		ST_RRESP = 2'b11
	} fsm_t;

endpackage

// file: verification/sb_mem_model.sv
// Behavioural system bus memory that answers the translator's bus cycles
`timescale 1ns/1ps
`default_nettype none
module sb_mem_model (
	input  wire logic        mclk_i,      // Clock
	input  wire logic        resetn_i,    // Reset, active low
	input  wire logic        req_i,       // Bus cycle request
	input  wire logic        we_i,        // Write cycle
	input  wire logic [23:0] addr_i,      // Byte address
	input  wire logic [5:0]  am_i,        // Address modifier
	input  wire logic [3:0]  be_i,        // Byte lanes
	input  wire logic [31:0] wdata_i,     // Write data
	input  wire logic [3:0]  delay_i,     // Cycles before answering
	input  wire logic        mute_i,      // Never answer while set
	output logic             ack_o,       // Memory response
	output logic [31:0]      rdata_o,     // Read data
	output logic [23:0]      seen_addr_o, // Address of last cycle
	output logic [5:0]       seen_am_o,   // Modifier of last cycle
	output logic [3:0]       seen_be_o    // Lanes of last cycle
);
	logic [31:0] mem [logic [21:0]];
	logic [31:0] word;
	logic [3:0]  cnt;

	// Answer after delay_i cycles, hold ack until the request drops
	always @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ack_o   <= 1'b0;
			cnt     <= 4'h0;
			rdata_o <= 32'h0;
		end else if (req_i && !ack_o) begin
			if (cnt < delay_i || mute_i) begin
				cnt <= cnt + 4'h1;
			end else begin
				// Unwritten words read back their own address
				word = mem.exists(addr_i[23:2]) ? mem[addr_i[23:2]]
					: {8'h00, addr_i};
				for (int b = 0; b < 4; b++)
					if (we_i && be_i[b])
						word[8*b+:8] = wdata_i[8*b+:8];
				if (we_i)
					mem[addr_i[23:2]] = word;
				rdata_o     <= word;
				ack_o       <= 1'b1;
				seen_addr_o <= addr_i;
				seen_am_o   <= am_i;
				seen_be_o   <= be_i;
			end
		end else if (!req_i) begin
			// Released data lines show garbage, never the old word
			if (ack_o)
				rdata_o <= ~rdata_o;
			ack_o <= 1'b0;
			cnt   <= 4'h0;
		end
	end
endmodule
`default_nettype wire

// file: verification/test_host_memory_address_translator.sv
// Self-checking bench for the host memory address translator
`timescale 1ns/1ps
`default_nettype none
module test_host_memory_address_translator;
	localparam int TMO = 50;
	localparam int LIM = 400;
	logic        mclk_i = 1'b0, resetn_i = 1'b0, mute = 1'b0;
	logic [17:0] s_axi_awaddr_i = 18'h0, s_axi_araddr_i = 18'h0;
	logic [31:0] s_axi_wdata_i = 32'h0, s_axi_rdata_o, sb_wdata_o, sb_rdata_i;
	logic [31:0] rd;
	logic [3:0]  s_axi_wstrb_i = 4'h0, sb_be_o, seen_be, delay = 4'h1;
	logic        s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0;
	logic        s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
	logic        s_axi_bready_i = 1'b0, s_axi_awready_o, s_axi_wready_o;
	logic        s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
	logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, resp;
	logic        sb_req_o, sb_we_o, sb_ack_i, bus_active_led_o;
	logic [23:0] sb_addr_o, seen_addr;
	logic [5:0]  sb_am_o, seen_am;
	logic [7:0]  status_led_o;
	logic [17:0] wofs [3] = '{18'h2fffc, 18'h30000, 18'h3fffc};
	int          n_errors = 0, n_tests = 0, n_req = 0, n_ba, n_dark;

	host_memory_address_translator #(
		.TIMEOUT_CYCLES(TMO),
		.FLASH_CYCLES  (8)
	) dut_u (
		.mclk_i(mclk_i), .resetn_i(resetn_i),
		.s_axi_awaddr_i(s_axi_awaddr_i), .s_axi_awvalid_i(s_axi_awvalid_i),
		.s_axi_awready_o(s_axi_awready_o), .s_axi_wdata_i(s_axi_wdata_i),
		.s_axi_wstrb_i(s_axi_wstrb_i), .s_axi_wvalid_i(s_axi_wvalid_i),
		.s_axi_wready_o(s_axi_wready_o), .s_axi_bresp_o(s_axi_bresp_o),
		.s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
		.s_axi_araddr_i(s_axi_araddr_i), .s_axi_arvalid_i(s_axi_arvalid_i),
		.s_axi_arready_o(s_axi_arready_o), .s_axi_rdata_o(s_axi_rdata_o),
		.s_axi_rresp_o(s_axi_rresp_o), .s_axi_rvalid_o(s_axi_rvalid_o),
		.s_axi_rready_i(s_axi_rready_i), .sb_req_o(sb_req_o),
		.sb_we_o(sb_we_o), .sb_addr_o(sb_addr_o), .sb_am_o(sb_am_o),
		.sb_be_o(sb_be_o), .sb_wdata_o(sb_wdata_o), .sb_ack_i(sb_ack_i),
		.sb_rdata_i(sb_rdata_i), .bus_active_led_o(bus_active_led_o),
		.status_led_o(status_led_o)
	);

	sb_mem_model mem_u (
		.mclk_i(mclk_i), .resetn_i(resetn_i), .req_i(sb_req_o),
		.we_i(sb_we_o), .addr_i(sb_addr_o), .am_i(sb_am_o), .be_i(sb_be_o),
		.wdata_i(sb_wdata_o), .delay_i(delay), .mute_i(mute),
		.ack_o(sb_ack_i), .rdata_o(sb_rdata_i), .seen_addr_o(seen_addr),
		.seen_am_o(seen_am), .seen_be_o(seen_be)
	);

	// 50 MHz clock
	always #10 mclk_i = ~mclk_i;

	// Bus cycles started, to prove that refused accesses stay off the bus
	always @(posedge sb_req_o) n_req++;

	// ----------------------------------------------------------------
	// Checking and closing
	// ----------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic summarize();
		if (n_errors == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// The indicator must follow the bus request in every cycle
	always @(negedge mclk_i)
		if (resetn_i)
			chk("led", bus_active_led_o, sb_req_o);

	// ----------------------------------------------------------------
	// AXI4-Lite master: ready sampled at negedge, acted on at posedge
	// ----------------------------------------------------------------
	task automatic axi_wr(input logic [17:0] a, input logic [31:0] d,
			input logic [3:0] s);
		int k;
		logic ta, tw, tb;
		@(posedge mclk_i);
		s_axi_awaddr_i  <= a;
		s_axi_wdata_i   <= d;
		s_axi_wstrb_i   <= s;
		s_axi_awvalid_i <= 1'b1;
		s_axi_wvalid_i  <= 1'b1;
		s_axi_bready_i  <= 1'b1;
		for (k = 0; k < LIM; k++) begin
			@(negedge mclk_i);
			ta = s_axi_awready_o;
			tw = s_axi_wready_o;
			tb = s_axi_bvalid_o;
			resp = s_axi_bresp_o;
			@(posedge mclk_i);
			if (ta)
				s_axi_awvalid_i <= 1'b0;
			if (tw)
				s_axi_wvalid_i <= 1'b0;
			if (tb)
				break;
		end
		s_axi_bready_i <= 1'b0;
		if (k == LIM) begin
			n_errors++;
			summarize();
		end
	endtask

	task automatic axi_rd(input logic [17:0] a);
		int k;
		logic ta, tr;
		@(posedge mclk_i);
		s_axi_araddr_i  <= a;
		s_axi_arvalid_i <= 1'b1;
		s_axi_rready_i  <= 1'b1;
		for (k = 0; k < LIM; k++) begin
			@(negedge mclk_i);
			ta = s_axi_arready_o;
			tr = s_axi_rvalid_o;
			rd = s_axi_rdata_o;
			resp = s_axi_rresp_o;
			@(posedge mclk_i);
			if (ta)
				s_axi_arvalid_i <= 1'b0;
			if (tr)
				break;
		end
		s_axi_rready_i <= 1'b0;
		if (k == LIM) begin
			n_errors++;
			summarize();
		end
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (4) @(posedge mclk_i);
		resetn_i <= 1'b1;
		@(posedge mclk_i);
		// Reset state, read-only status and an unmapped place
		axi_rd(hmat_pkg::REG_CTRL);
		chk("ctrl", rd, 32'h0);
		axi_wr(hmat_pkg::REG_STATUS, 32'hffffffff, 4'hf);
		axi_rd(hmat_pkg::REG_STATUS);
		chk("status", rd, 32'h0);
		axi_rd(18'h00014);
		chk("unmapped", resp, hmat_pkg::RESP_DECERR);
		// Segmented: offset in low half, segment in high half
		axi_wr(hmat_pkg::REG_ADDR, 32'h12345678, 4'hf);
		axi_rd(hmat_pkg::REG_BASE);
		chk("seg base", rd & 32'h00ffffff, 32'h000179b8);
		axi_wr(18'h20010, 32'hcafef00d, 4'hf);
		chk("seg addr", seen_addr, 24'h0179c8);
		axi_rd(18'h20010);
		chk("seg data", rd, 32'hcafef00d);
		// Segmented sum wraps within the first Mbyte
		axi_wr(hmat_pkg::REG_ADDR, 32'hffff0020, 4'hf);
		axi_rd(18'h20000);
		chk("seg wrap", seen_addr, 24'h000010);
		// Absolute mode, slow memory, across the window boundary
		axi_wr(hmat_pkg::REG_CTRL, 32'h1, 4'hf);
		axi_wr(hmat_pkg::REG_ADDR, 32'h00ab0000, 4'hf);
		delay <= 4'h9;
		for (int i = 0; i < 3; i++) begin
			axi_rd(wofs[i]);
			chk("abs addr", seen_addr, 24'hab0000 + wofs[i][16:0]);
		end
		delay <= 4'h0;
		// VMEbus: modifier travels with the bus cycle
		axi_wr(hmat_pkg::REG_CTRL, 32'h8, 4'hf);
		axi_wr(hmat_pkg::REG_ADDR, 32'h2d123454, 4'hf);
		axi_rd(hmat_pkg::REG_BASE);
		chk("vme base", rd, 32'h2d123454);
		axi_rd(18'h20000);
		chk("vme am", seen_am, 6'h2d);
		chk("vme addr", seen_addr, 24'h123454);
		// Every conversion pattern sets its own flags
		axi_wr(hmat_pkg::REG_CTRL, 32'h3, 4'hf);
		for (int i = 0; i < 4; i++) begin
			axi_wr(hmat_pkg::REG_PATTERN, 32'(i), 4'hf);
			axi_rd(hmat_pkg::REG_STATUS);
			chk("conv flags", rd, 32'(i) << 2);
		end
		// Host longword order undone on the address object
		axi_wr(hmat_pkg::REG_ADDR, 32'h56341200, 4'hf);
		axi_rd(hmat_pkg::REG_BASE);
		chk("conv base", rd & 32'h00ffffff, 32'h00123456);
		// Converted byte write lands on the partner byte
		axi_wr(18'h20003, 32'h77000000, 4'h8);
		chk("byte addr", seen_addr, 24'h123458);
		chk("byte lane", seen_be, 4'h1);
		axi_wr(hmat_pkg::REG_CTRL, 32'h1, 4'hf);
		axi_wr(18'h20003, 32'h77000000, 4'h8);
		chk("plain addr", seen_addr, 24'h123459);
		// Without timeout a silent memory is waited for
		mute <= 1'b1;
		fork
			axi_rd(18'h20000);
			begin
				repeat (200) @(posedge mclk_i);
				chk("still waiting", sb_req_o, 1'b1);
				mute <= 1'b0;
			end
		join
		chk("late resp", resp, hmat_pkg::RESP_OKAY);
		// With timeout: offline, error answered, code flashed
		axi_wr(hmat_pkg::REG_CTRL, 32'h5, 4'hf);
		mute <= 1'b1;
		axi_rd(18'h20000);
		chk("tmo resp", resp, hmat_pkg::RESP_SLVERR);
		axi_rd(hmat_pkg::REG_STATUS);
		chk("offline", rd[1], 1'b1);
		n_ba = n_req;
		axi_wr(18'h20000, 32'h0, 4'hf);
		chk("off resp", resp, hmat_pkg::RESP_SLVERR);
		chk("off cycles", n_req, n_ba);
		n_ba = 0;
		n_dark = 0;
		repeat (40) begin
			@(negedge mclk_i);
			n_ba += int'(status_led_o === hmat_pkg::ERR_CODE);
			n_dark += int'(status_led_o === 8'h00);
		end
		chk("flash on", n_ba > 0, 1'b1);
		chk("flash off", n_dark > 0, 1'b1);
		summarize();
	end
endmodule
`default_nettype wire
